// *** shared/nest_irq_pkg.sv ***
// Constants shared by the nested interrupt controller files
package nest_irq_pkg;
    localparam int unsigned PRIO_W        = 4;
    localparam int unsigned DETECT_W      = 2;
    localparam int unsigned VECTOR_W      = 8;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned PSW_ENTRY_W   = PRIO_W + 1;
    // Vector of the first external source
    localparam logic [VECTOR_W-1:0] FIRST_VECTOR = 8'h41;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] PSW_ADDR     = 12'h000;
    localparam logic [ADDR_W-1:0] PENDING_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] ENABLE_ADDR  = 12'h008;
    localparam logic [ADDR_W-1:0] CFG_BASE     = 12'h010;
    localparam logic [ADDR_W-1:0] CFG_STRIDE   = 12'h004;
    // Field positions
    localparam int unsigned PSW_GFLAG_BIT  = 0;
    localparam int unsigned PSW_LEVEL_LSB  = 4;
    localparam int unsigned CFG_PRIO_LSB   = 0;
    localparam int unsigned CFG_DETECT_LSB = 4;
    // Reset values
    localparam logic              GFLAG_RESET  = 1'b0;
    localparam logic [PRIO_W-1:0] LEVEL_RESET  = 4'h0;
    localparam logic [PRIO_W-1:0] PRIO_RESET   = 4'h0;
    localparam logic [DATA_W-1:0] ZERO_WORD    = 32'h0000_0000;
    // Pin detection settings
    typedef enum logic [DETECT_W-1:0] {
        DETECT_LOW     = 2'h0,
        DETECT_FALLING = 2'h1,
        DETECT_RISING  = 2'h2,
        DETECT_BOTH    = 2'h3
    } detect_type;
endpackage

// *** rtl/psw_stack.sv ***
// Stack of saved status words for nested handlers
`timescale 1ns/1ps
module psw_stack #(
    parameter int unsigned WIDTH = 5,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             push_i,
    input  wire logic             pop_i,
    input  wire logic [WIDTH-1:0] push_data_i,
    output logic      [WIDTH-1:0] top_o,
    output logic                  full_o,
    output logic                  empty_o
);
    localparam int unsigned PTR_W = $clog2(DEPTH + 1);

    if (WIDTH < 1 || DEPTH < 1) begin : g_bad_params
        $error("psw_stack: WIDTH and DEPTH must be at least one");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            ptr;
        logic [WIDTH-1:0]            top;
    } stack_state_type;

    stack_state_type s_q;
    stack_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (push_i && (s_q.ptr != PTR_W'(DEPTH))) begin
            s_d.mem[s_q.ptr] = push_data_i;
            s_d.ptr          = s_q.ptr + PTR_W'(1);
            s_d.top          = push_data_i;
        end else if (pop_i && (s_q.ptr != '0)) begin
            s_d.ptr = s_q.ptr - PTR_W'(1);
            s_d.top = (s_q.ptr > PTR_W'(1)) ? s_q.mem[s_q.ptr - PTR_W'(2)] : '0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign top_o   = s_q.top;
    assign full_o  = (s_q.ptr == PTR_W'(DEPTH));
    assign empty_o = (s_q.ptr == '0);
endmodule // psw_stack

// *** rtl/nest_irq_ctrl.sv ***
// Nested priority interrupt controller with APB registers
`timescale 1ns/1ps
module nest_irq_ctrl
    import nest_irq_pkg::*;
#(
    parameter int unsigned NSRC       = 4,
    parameter int unsigned NEST_DEPTH = 8
) (
    input  wire logic                                mclk_i,
    input  wire logic                                rst_n_i,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [nest_irq_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [nest_irq_pkg::DATA_W-1:0]     pwdata,
    output logic      [nest_irq_pkg::DATA_W-1:0]     prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic [NSRC-1:0]                     ext_req_n_i,
    output logic                                     int_req_o,
    output logic      [nest_irq_pkg::VECTOR_W-1:0]   int_vector_o,
    output logic      [nest_irq_pkg::PRIO_W-1:0]     int_level_o,
    input  wire logic                                int_take_i,
    input  wire logic                                int_return_i,
    output logic                                     global_enable_o,
    output logic      [nest_irq_pkg::PRIO_W-1:0]     current_level_o
);
    import nest_irq_pkg::*;

    localparam int unsigned IDX_W = (NSRC > 1) ? $clog2(NSRC) : 1;

    if (NSRC < 1 || NSRC > DATA_W || NSRC > 64) begin : g_bad_nsrc
        $error("nest_irq_ctrl: NSRC out of range");
    end
    if (NEST_DEPTH < 1) begin : g_bad_depth
        $error("nest_irq_ctrl: NEST_DEPTH must be at least one");
    end

    typedef struct packed {
        logic                             gflag;
        logic [PRIO_W-1:0]                level;
        logic [NSRC-1:0]                  pend;
        logic [NSRC-1:0]                  enable;
        logic [NSRC-1:0][PRIO_W-1:0]      prio;
        logic [NSRC-1:0][DETECT_W-1:0]    detect;
        logic [NSRC-1:0]                  pin_prev;
        logic                             req;
        logic [IDX_W-1:0]                 sel_idx;
        logic [PRIO_W-1:0]                sel_prio;
        logic [VECTOR_W-1:0]              vector;
        logic [DATA_W-1:0]                rdata;
        logic                             slverr;
    } ctrl_state_type;

    ctrl_state_type s_q;
    ctrl_state_type s_d;

    logic                   push;
    logic                   pop;
    logic [PSW_ENTRY_W-1:0] saved_psw;
    logic                   stack_full;
    logic                   stack_empty;

    // Byte address of a source's configuration word
    function automatic logic [ADDR_W-1:0] cfg_addr(input int unsigned idx);
        cfg_addr = CFG_BASE + ADDR_W'(idx) * CFG_STRIDE;
    endfunction

    // Edge or level seen on a pin under a detection setting
    function automatic logic pin_event(input detect_type mode, input logic now_low, input logic was_low);
        unique case (mode)
            DETECT_LOW:     pin_event = now_low;
            DETECT_FALLING: pin_event = now_low && !was_low;
            DETECT_RISING:  pin_event = !now_low && was_low;
            DETECT_BOTH:    pin_event = now_low != was_low;
        endcase
    endfunction

    logic                 apb_wr;
    logic                 apb_rd;
    logic                 hit;
    logic [DATA_W-1:0]    rd_word;
    logic                 best_found;
    logic [IDX_W-1:0]     best_idx;
    logic [PRIO_W-1:0]    best_prio;
    logic                 accept;
    logic                 ret;

    always_comb begin
        s_d        = s_q;
        apb_wr     = psel && penable && pwrite;
        apb_rd     = psel && !penable && !pwrite;
        hit        = 1'b0;
        rd_word    = ZERO_WORD;
        best_found = 1'b0;
        best_idx   = '0;
        best_prio  = '0;
        accept     = int_take_i && s_q.req;
        ret        = int_return_i && !accept && !stack_empty;
        push       = accept;
        pop        = ret;

        // Pin sensing and pending flags
        for (int i = 0; i < NSRC; i++) begin
            s_d.pin_prev[i] = !ext_req_n_i[i];
            if (detect_type'(s_q.detect[i]) == DETECT_LOW) begin
                s_d.pend[i] = !ext_req_n_i[i];
            end else begin
                if (accept && (s_q.sel_idx == IDX_W'(i))) begin
                    s_d.pend[i] = 1'b0;
                end
                if (apb_wr && (paddr == PENDING_ADDR) && pwdata[i]) begin
                    s_d.pend[i] = 1'b0;
                end
                if (pin_event(detect_type'(s_q.detect[i]), !ext_req_n_i[i], s_q.pin_prev[i])) begin
                    s_d.pend[i] = 1'b1;
                end
            end
        end

        // Register writes
        if (apb_wr) begin
            if (paddr == PSW_ADDR) begin
                s_d.gflag = pwdata[PSW_GFLAG_BIT];
            end
            if (paddr == ENABLE_ADDR) begin
                s_d.enable = pwdata[NSRC-1:0];
            end
            for (int i = 0; i < NSRC; i++) begin
                if (paddr == cfg_addr(i)) begin
                    s_d.prio[i]   = pwdata[CFG_PRIO_LSB +: PRIO_W];
                    s_d.detect[i] = pwdata[CFG_DETECT_LSB +: DETECT_W];
                end
            end
        end

        // Acceptance and return
        if (accept) begin
            s_d.gflag = 1'b0;
            s_d.level = s_q.sel_prio;
        end else if (ret) begin
            s_d.gflag = saved_psw[PRIO_W];
            s_d.level = saved_psw[PRIO_W-1:0];
        end

        // Highest priority enabled source, lowest index on a tie
        for (int i = 0; i < NSRC; i++) begin
            if (s_q.pend[i] && s_q.enable[i] && (s_q.prio[i] > best_prio)) begin
                best_found = 1'b1;
                best_idx   = IDX_W'(i);
                best_prio  = s_q.prio[i];
            end
        end
        s_d.req      = best_found && s_q.gflag && (best_prio > s_q.level)
                       && !accept && !stack_full;
        s_d.sel_idx  = best_idx;
        s_d.sel_prio = best_prio;
        s_d.vector   = FIRST_VECTOR + VECTOR_W'(best_idx);

        // Register reads
        if (psel && !penable) begin
            if (paddr == PSW_ADDR) begin
                hit                                  = 1'b1;
                rd_word[PSW_GFLAG_BIT]               = s_q.gflag;
                rd_word[PSW_LEVEL_LSB +: PRIO_W]     = s_q.level;
            end
            if (paddr == PENDING_ADDR) begin
                hit                = 1'b1;
                rd_word[NSRC-1:0]  = s_q.pend;
            end
            if (paddr == ENABLE_ADDR) begin
                hit                = 1'b1;
                rd_word[NSRC-1:0]  = s_q.enable;
            end
            for (int i = 0; i < NSRC; i++) begin
                if (paddr == cfg_addr(i)) begin
                    hit                                = 1'b1;
                    rd_word[CFG_PRIO_LSB +: PRIO_W]    = s_q.prio[i];
                    rd_word[CFG_DETECT_LSB +: DETECT_W] = s_q.detect[i];
                end
            end
            s_d.rdata  = apb_rd ? rd_word : ZERO_WORD;
            s_d.slverr = !hit;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q          <= '0;
            s_q.gflag    <= GFLAG_RESET;
            s_q.level    <= LEVEL_RESET;
            s_q.prio     <= {NSRC{PRIO_RESET}};
            s_q.pin_prev <= '0;
            s_q.vector   <= FIRST_VECTOR;
        end else begin
            s_q <= s_d;
        end
    end

    psw_stack #(
        .WIDTH (PSW_ENTRY_W),
        .DEPTH (NEST_DEPTH)
    ) u_psw_stack (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .push_i      (push),
        .pop_i       (pop),
        .push_data_i ({s_q.gflag, s_q.level}),
        .top_o       (saved_psw),
        .full_o      (stack_full),
        .empty_o     (stack_empty)
    );

    assign prdata          = s_q.rdata;
    assign pready          = 1'b1;
    assign pslverr         = psel && penable && s_q.slverr;
    assign int_req_o       = s_q.req;
    assign int_vector_o    = s_q.vector;
    assign int_level_o     = s_q.sel_prio;
    assign global_enable_o = s_q.gflag;
    assign current_level_o = s_q.level;
endmodule // nest_irq_ctrl

// *** bench/nest_irq_monitor.sv ***
// Port checker for the nested interrupt controller
`timescale 1ns/1ps
module nest_irq_monitor
    import nest_irq_pkg::*;
#(
    parameter int unsigned NSRC = 4
) (
    input wire logic                       mclk_i,
    input wire logic                       rst_n_i,
    input wire logic                       int_req_o,
    input wire logic [nest_irq_pkg::VECTOR_W-1:0] int_vector_o,
    input wire logic [nest_irq_pkg::PRIO_W-1:0]   int_level_o,
    input wire logic                       int_take_i,
    input wire logic                       int_return_i,
    input wire logic                       global_enable_o,
    input wire logic [nest_irq_pkg::PRIO_W-1:0]   current_level_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_take_clears;
        int_req_o && int_take_i |=> !global_enable_o && current_level_o == $past(int_level_o);
    endproperty
    a_take_clears: assert property (p_take_clears) else $error("flag or level wrong after take");
    property p_take_drops;
        int_req_o && int_take_i |=> !int_req_o;
    endproperty
    a_take_drops: assert property (p_take_drops) else $error("offer held after take");
    property p_flag_masks;
        !global_enable_o && !$past(global_enable_o) |-> !int_req_o;
    endproperty
    a_flag_masks: assert property (p_flag_masks) else $error("offer while flag clear");
    property p_strict;
        int_req_o |-> int_level_o > current_level_o;
    endproperty
    a_strict: assert property (p_strict) else $error("offer not above running level");
    property p_level_moves;
        $changed(current_level_o) |-> $past(int_take_i) || $past(int_return_i);
    endproperty
    a_level_moves: assert property (p_level_moves) else $error("running level changed alone");
    property p_prio_nonzero;
        int_req_o |-> int_level_o != 4'h0;
    endproperty
    a_prio_nonzero: assert property (p_prio_nonzero) else $error("offer at priority zero");
    property p_vector;
        int_req_o |-> int_vector_o >= FIRST_VECTOR && int_vector_o < FIRST_VECTOR + NSRC;
    endproperty
    a_vector: assert property (p_vector) else $error("vector out of range");
    property p_return;
        int_return_i && !int_take_i && current_level_o != 4'h0 |=> current_level_o < $past(current_level_o);
    endproperty
    a_return: assert property (p_return) else $error("return did not restore level");
endmodule // nest_irq_monitor

bind nest_irq_ctrl nest_irq_monitor #(.NSRC(NSRC)) mon_u (.mclk_i, .rst_n_i, .int_req_o, .int_vector_o,
    .int_level_o, .int_take_i, .int_return_i, .global_enable_o, .current_level_o);

// *** bench/core_model.sv ***
// Core model that takes each offer and returns on command
`timescale 1ns/1ps
module core_model (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic req_i,
    input  wire logic ret_cmd_i,
    output logic      take_o,
    output logic      return_o
);
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            take_o   <= 1'b0;
            return_o <= 1'b0;
        end else begin
            take_o   <= req_i && !take_o;
            return_o <= ret_cmd_i;
        end
    end
endmodule // core_model

// *** bench/tb.sv ***
// Testbench for the nested interrupt controller
`timescale 1ns/1ps
module tb;
    import nest_irq_pkg::*;
    logic                mclk_i = 1'b0;
    logic                rst_n_i = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [ADDR_W-1:0]   paddr = 12'h000;
    logic [DATA_W-1:0]   pwdata = 32'h0000_0000;
    logic [3:0]          ext_req_n_i = 4'hF;
    logic                ret_cmd = 1'b0;
    logic [DATA_W-1:0]   prdata, rd;
    logic                pready, pslverr, int_req_o, int_take_i, int_return_i, global_enable_o, err;
    logic [VECTOR_W-1:0] int_vector_o;
    logic [PRIO_W-1:0]   int_level_o, current_level_o;
    int                  n_mismatch = 0;
    int                  compares = 0;
    always #4 mclk_i = ~mclk_i;
    nest_irq_ctrl #(.NSRC(4), .NEST_DEPTH(8)) dut_u (.mclk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_req_n_i, .int_req_o, .int_vector_o, .int_level_o,
        .int_take_i, .int_return_i, .global_enable_o, .current_level_o);
    core_model core_u (.mclk_i, .rst_n_i, .req_i(int_req_o), .ret_cmd_i(ret_cmd), .take_o(int_take_i),
        .return_o(int_return_i));
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_lvl(input logic [PRIO_W-1:0] lvl);
        for (int i = 0; i < 20 && current_level_o !== lvl; i++) @(posedge mclk_i);
        chk("current_level_o", current_level_o, lvl);
    endtask
    task offer(input logic [VECTOR_W-1:0] vec, input logic [PRIO_W-1:0] lvl);
        for (int i = 0; i < 20 && int_req_o !== 1'b1; i++) @(posedge mclk_i);
        chk("int_req_o", int_req_o, 1);
        chk("int_vector_o", int_vector_o, vec);
        chk("int_level_o", int_level_o, lvl);
        wait_lvl(lvl);
        chk("global_enable_o", global_enable_o, 0);
    endtask
    task no_offer;
        repeat (6) begin
            @(posedge mclk_i);
            chk("int_req_o", int_req_o, 0);
        end
    endtask
    task ret(input logic [PRIO_W-1:0] lvl);
        ret_cmd <= 1'b1;
        @(posedge mclk_i);
        ret_cmd <= 1'b0;
        wait_lvl(lvl);
        chk("global_enable_o", global_enable_o, 1);
    endtask
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, PSW_ADDR, ZERO_WORD);
        chk("psw reset", rd, ZERO_WORD);
        apb(1'b0, 12'h0FC, ZERO_WORD);
        chk("unmapped pslverr", err, 1);
        chk("unmapped prdata", rd, ZERO_WORD);
        apb(1'b1, CFG_BASE, 32'h0000_0001);
        apb(1'b1, CFG_BASE + CFG_STRIDE, 32'h0000_0002);
        apb(1'b1, ENABLE_ADDR, 32'h0000_0003);
        apb(1'b1, PSW_ADDR, 32'h0000_0001);
        ext_req_n_i <= 4'hE;
        offer(8'h41, 4'h1);
        apb(1'b0, PENDING_ADDR, ZERO_WORD);
        chk("pending low pin", rd, 32'h0000_0001);
        ext_req_n_i <= 4'hC;
        no_offer();
        apb(1'b1, PSW_ADDR, 32'h0000_0001);
        offer(8'h42, 4'h2);
        apb(1'b1, PSW_ADDR, 32'h0000_0001);
        no_offer();
        ext_req_n_i <= 4'hE;
        ret(4'h1);
        no_offer();
        ext_req_n_i <= 4'hF;
        apb(1'b0, PENDING_ADDR, ZERO_WORD);
        chk("pending released", rd, ZERO_WORD);
        ret(4'h0);
        apb(1'b0, PSW_ADDR, ZERO_WORD);
        chk("psw restored", rd, 32'h0000_0001);
        apb(1'b1, PSW_ADDR, ZERO_WORD);
        apb(1'b1, CFG_BASE + CFG_STRIDE, 32'h0000_0032);
        apb(1'b1, ADDR_W'(CFG_BASE + 2 * CFG_STRIDE), 32'h0000_0013);
        apb(1'b1, ADDR_W'(CFG_BASE + 3 * CFG_STRIDE), 32'h0000_0021);
        apb(1'b1, ENABLE_ADDR, 32'h0000_0007);
        ext_req_n_i <= 4'h1;
        apb(1'b0, PENDING_ADDR, ZERO_WORD);
        chk("pending falling", rd, 32'h0000_0006);
        ext_req_n_i <= 4'hF;
        apb(1'b0, PENDING_ADDR, ZERO_WORD);
        chk("pending rising", rd, 32'h0000_000E);
        apb(1'b1, PENDING_ADDR, 32'h0000_000E);
        apb(1'b0, PENDING_ADDR, ZERO_WORD);
        chk("pending cleared", rd, ZERO_WORD);
        ext_req_n_i <= 4'hB;
        @(posedge mclk_i);
        ext_req_n_i <= 4'hF;
        apb(1'b1, PSW_ADDR, 32'h0000_0001);
        offer(8'h43, 4'h3);
        apb(1'b0, PENDING_ADDR, ZERO_WORD);
        chk("pending taken", rd, ZERO_WORD);
        ret(4'h0);
        end_of_test();
    end
    initial begin
        repeat (3000) @(posedge mclk_i);
        n_mismatch++;
        end_of_test();
    end
endmodule // tb
